/* logic/charger_i2c_pkg.sv */
package charger_i2c_pkg;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h5A;
  // arbitrary neutral identity value
  localparam logic [7:0] PART_ID_DEFAULT = 8'hA5;
  localparam logic [7:0] REG_PART_ID = 8'h00;
  localparam logic [7:0] REG_CHARGER_FLAGS = 8'h01;
  localparam logic [7:0] REG_GENERAL_FLAGS = 8'h02;
  localparam logic [7:0] REG_INT_MASK = 8'h03;
  localparam logic [7:0] REG_FUNC_CTRL = 8'h04;
  localparam logic [7:0] REG_CHARGE_CURRENT = 8'h05;
  localparam logic [7:0] REG_CHARGE_VOLTAGE = 8'h06;
  localparam logic [7:0] REG_HEALTH_SINK = 8'h07;
  localparam logic [7:0] REG_SOFT_RESET = 8'h08;
  localparam logic [7:0] REG_NULL_OP = 8'hFF;
  localparam int CHG_ENABLE_BIT = 3;
  localparam int CHG_ACTIVE_BIT = 7;
  localparam logic [7:0] SETTING5_MASK = 8'h1F;
  localparam logic [7:0] CTRL_MASK = 8'hDF;
  localparam logic [2:0] PHASE_STANDBY = 3'h0;
  localparam logic [2:0] PHASE_PREQUAL = 3'h2;
  localparam logic [2:0] PHASE_CC = 3'h6;
  localparam logic [2:0] PHASE_CV = 3'h7;
  localparam logic [2:0] PHASE_DONE = 3'h4;
  // controller APB map
  localparam logic [7:0] APB_CTRL = 8'h00;
  localparam logic [7:0] APB_PTR = 8'h04;
  localparam logic [7:0] APB_WDATA = 8'h08;
  localparam logic [7:0] APB_RDATA = 8'h0C;
  localparam logic [7:0] APB_STATUS = 8'h10;
  localparam logic [7:0] APB_IRQ_STAT = 8'h14;
  localparam logic [7:0] APB_IRQ_MASK = 8'h18;
  localparam logic [7:0] APB_DIV = 8'h1C;
  localparam logic [15:0] DIV_DEFAULT = 16'h0006;
endpackage

/* logic/i2c_link_if.sv */
`timescale 1ns/1ps
interface i2c_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  // open-drain wired-and with pullups
  wire scl = !(scl_oe && !scl_o);
  wire sda = !(sda_m_oe && !sda_m_o) && !(sda_s_oe && !sda_s_o);
  modport master (output scl_o, scl_oe, sda_m_o, sda_m_oe, input scl, sda);
  modport slave (output sda_s_o, sda_s_oe, input scl, sda);
endinterface

/* logic/charger_i2c_slave.sv */
// Added by the designer: the I2C register port.
`timescale 1ns/1ps
module charger_i2c_slave
  import charger_i2c_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT,
  parameter logic [7:0] PART_ID = PART_ID_DEFAULT
) (
  input wire logic core_clk,
  input wire logic rst,
  i2c_link_if.slave link,
  input wire logic [2:0] charger_phase,
  input wire logic undervoltage_lockout,
  input wire logic input_undervoltage_flag,
  input wire logic input_overvoltage_flag,
  input wire logic input_below_battery_flag,
  input wire logic [7:0] general_state_flags,
  output logic status_interrupt_output_n,
  output logic [7:0] function_control_q,
  output logic [7:0] charge_current_q,
  output logic [7:0] charge_voltage_q,
  output logic [7:0] health_sink_q,
  output logic soft_reset_pulse_q
);
  typedef enum {S_IDLE, S_ADDR, S_ADDR_ACK, S_RX, S_RX_ACK, S_TX, S_TX_ACK} st_t;

  st_t st_q;
  logic [1:0] scl_sync_q, sda_sync_q;
  logic scl_q, sda_q;
  logic [7:0] sh_q;
  logic [3:0] bit_q;
  logic [7:0] ptr_q;
  logic [7:0] mask_q;
  logic byte_idx_q;
  logic rd_q;
  logic sda_oe_q;
  logic [7:0] rd_val;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], link.scl};
      sda_sync_q <= {sda_sync_q[0], link.sda};
      scl_q <= scl_sync_q[1];
      sda_q <= sda_sync_q[1];
    end
  end

  wire scl_s = scl_sync_q[1];
  wire sda_s = sda_sync_q[1];
  wire scl_rise = scl_s && !scl_q;
  wire scl_fall = !scl_s && scl_q;
  wire start_c = scl_s && scl_q && sda_q && !sda_s;
  wire stop_c = scl_s && scl_q && !sda_q && sda_s;

  function automatic logic [7:0] read_reg(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      REG_PART_ID: v = PART_ID;
      REG_CHARGER_FLAGS: begin
        v[CHG_ACTIVE_BIT] = function_control_q[CHG_ENABLE_BIT] && !undervoltage_lockout;
        case (charger_phase)
          PHASE_STANDBY, PHASE_PREQUAL, PHASE_CC, PHASE_CV, PHASE_DONE: v[6:4] = charger_phase;
          default: v[6:4] = PHASE_STANDBY;
        endcase
        v[2] = input_undervoltage_flag || !function_control_q[CHG_ENABLE_BIT];
        v[1] = input_overvoltage_flag;
        v[0] = input_below_battery_flag;
      end
      REG_GENERAL_FLAGS: v = general_state_flags;
      REG_INT_MASK: v = mask_q;
      REG_FUNC_CTRL: v = function_control_q;
      REG_CHARGE_CURRENT: v = charge_current_q;
      REG_CHARGE_VOLTAGE: v = charge_voltage_q;
      REG_HEALTH_SINK: v = health_sink_q;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  always_comb rd_val = read_reg(ptr_q);

  // protocol engine
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_q <= S_IDLE;
      sh_q <= 8'h00;
      bit_q <= 4'h0;
      ptr_q <= 8'h00;
      byte_idx_q <= 1'b0;
      rd_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (start_c) begin
      st_q <= S_ADDR;
      bit_q <= 4'h0;
      sda_oe_q <= 1'b0;
    end else if (stop_c) begin
      st_q <= S_IDLE;
      sda_oe_q <= 1'b0;
    end else begin
      case (st_q)
        S_ADDR, S_RX: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s};
            bit_q <= bit_q + 4'h1;
          end
          if (scl_fall && bit_q == 4'h8) begin
            bit_q <= 4'h0;
            if (st_q == S_ADDR) begin
              if (sh_q[7:1] == DEV_ADDR) begin
                rd_q <= sh_q[0];
                byte_idx_q <= 1'b0;
                sda_oe_q <= 1'b1;
                st_q <= S_ADDR_ACK;
              end else begin
                st_q <= S_IDLE;
              end
            end else begin
              sda_oe_q <= 1'b1;
              st_q <= S_RX_ACK;
              if (!byte_idx_q) begin
                ptr_q <= sh_q;
              end
            end
          end
        end
        S_ADDR_ACK, S_RX_ACK: begin
          if (scl_fall) begin
            sda_oe_q <= 1'b0;
            if (st_q == S_RX_ACK) begin
              byte_idx_q <= 1'b1;
              st_q <= S_RX;
            end else if (rd_q) begin
              sh_q <= read_reg(ptr_q);
              sda_oe_q <= !rd_val[7];
              st_q <= S_TX;
            end else begin
              st_q <= S_RX;
            end
          end
        end
        S_TX: begin
          if (scl_fall) begin
            if (bit_q == 4'h7) begin
              bit_q <= 4'h0;
              sda_oe_q <= 1'b0;
              st_q <= S_TX_ACK;
            end else begin
              bit_q <= bit_q + 4'h1;
              sh_q <= {sh_q[6:0], 1'b0};
              sda_oe_q <= !sh_q[6];
            end
          end
        end
        S_TX_ACK: begin
          if (scl_rise) begin
            st_q <= sda_s ? S_IDLE : S_TX;
            sh_q <= read_reg(ptr_q);
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  wire wr_byte = !stop_c && !start_c && st_q == S_RX_ACK && scl_fall && byte_idx_q;

  // registers written from the data byte during its acknowledge slot
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mask_q <= 8'h00;
      function_control_q <= 8'h00;
      charge_current_q <= 8'h00;
      charge_voltage_q <= 8'h00;
      health_sink_q <= 8'h00;
      soft_reset_pulse_q <= 1'b0;
    end else begin
      soft_reset_pulse_q <= 1'b0;
      if (wr_byte) begin
        case (ptr_q)
          REG_INT_MASK: mask_q <= sh_q;
          REG_FUNC_CTRL: function_control_q <= sh_q & CTRL_MASK;
          REG_CHARGE_CURRENT: charge_current_q <= sh_q & SETTING5_MASK;
          REG_CHARGE_VOLTAGE: charge_voltage_q <= sh_q & SETTING5_MASK;
          REG_HEALTH_SINK: health_sink_q <= sh_q;
          REG_SOFT_RESET: soft_reset_pulse_q <= 1'b1;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_interrupt_output_n <= 1'b1;
    end else begin
      status_interrupt_output_n <= !(|(general_state_flags & mask_q));
    end
  end

  assign link.sda_s_o = 1'b0;
  assign link.sda_s_oe = sda_oe_q;
endmodule

/* logic/charger_i2c_master.sv */
`timescale 1ns/1ps
module charger_i2c_master
  import charger_i2c_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input wire logic core_clk,
  input wire logic rst,
  i2c_link_if.master link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);
  typedef enum {M_IDLE, M_START, M_BIT, M_STOP} mst_t;

  mst_t st_q;
  logic [15:0] div_q, cnt_q;
  logic [1:0] ph_q;
  logic [7:0] ptr_q, wdat_q, rdat_q, sh_q;
  logic [2:0] byte_q;
  logic [3:0] bit_q;
  logic rd_q, nack_q, busy_q, sda_drv_q, scl_lo_q;
  logic [1:0] irq_stat_q, irq_mask_q;
  logic [1:0] sda_sync_q;
  logic done_ev, nack_ev;

  wire sda_s = sda_sync_q[1];
  wire apb_acc = psel && penable;
  wire go = apb_acc && pready && pwrite && paddr == APB_CTRL && pwdata[0] && !busy_q;
  wire tick = cnt_q == 16'h0000;
  wire [2:0] last_byte = rd_q ? 3'h3 : 3'h2;

  function automatic logic [7:0] tx_byte(input logic [2:0] b);
    case (b)
      3'h0: return {DEV_ADDR, 1'b0};
      3'h1: return ptr_q;
      3'h2: return rd_q ? {DEV_ADDR, 1'b1} : wdat_q;
      default: return 8'hFF;
    endcase
  endfunction

  always_ff @(posedge core_clk) begin
    if (rst) sda_sync_q <= 2'h3;
    else sda_sync_q <= {sda_sync_q[0], link.sda};
  end

  always_ff @(posedge core_clk) begin
    if (rst || !(st_q != M_IDLE) || tick) cnt_q <= div_q;
    else cnt_q <= cnt_q - 16'h0001;
  end

  // four phases per bit: scl low set data, high, high sample, low
  always_ff @(posedge core_clk) begin
    done_ev <= 1'b0;
    nack_ev <= 1'b0;
    if (rst) begin
      st_q <= M_IDLE;
      ph_q <= 2'h0;
      byte_q <= 3'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rdat_q <= 8'h00;
      nack_q <= 1'b0;
      busy_q <= 1'b0;
      sda_drv_q <= 1'b1;
      scl_lo_q <= 1'b0;
      done_ev <= 1'b0;
      nack_ev <= 1'b0;
    end else if (go) begin
      st_q <= M_START;
      busy_q <= 1'b1;
      nack_q <= 1'b0;
      ph_q <= 2'h0;
      byte_q <= 3'h0;
    end else if (tick) begin
      ph_q <= ph_q + 2'h1;
      case (st_q)
        M_START: begin
          // phase 0 releases sda with scl high, 1 pulls sda, 2 pulls scl
          if (ph_q == 2'h0) begin
            sda_drv_q <= 1'b1;
            scl_lo_q <= 1'b0;
          end else if (ph_q == 2'h1) sda_drv_q <= 1'b0;
          else if (ph_q == 2'h2) begin
            scl_lo_q <= 1'b1;
            st_q <= M_BIT;
            bit_q <= 4'h0;
            sh_q <= tx_byte(byte_q);
            ph_q <= 2'h0;
          end
        end
        M_BIT: begin
          if (ph_q == 2'h0) begin
            scl_lo_q <= 1'b1;
            if (bit_q < 4'h8) sda_drv_q <= (byte_q == 3'h3) ? 1'b1 : sh_q[7];
            else sda_drv_q <= 1'b1;
          end else if (ph_q == 2'h1) scl_lo_q <= 1'b0;
          else if (ph_q == 2'h2) begin
            if (bit_q < 4'h8) begin
              sh_q <= {sh_q[6:0], sda_s};
            end else if (byte_q != 3'h3 && sda_s) begin
              nack_q <= 1'b1;
            end
          end else begin
            scl_lo_q <= 1'b1;
            if (bit_q == 4'h8) begin
              bit_q <= 4'h0;
              if (byte_q == 3'h3) rdat_q <= sh_q;
              if (nack_q || byte_q == last_byte) st_q <= M_STOP;
              else if (rd_q && byte_q == 3'h1) st_q <= M_START;
              else sh_q <= tx_byte(byte_q + 3'h1);
              byte_q <= byte_q + 3'h1;
            end else begin
              bit_q <= bit_q + 4'h1;
            end
          end
        end
        M_STOP: begin
          if (ph_q == 2'h0) sda_drv_q <= 1'b0;
          else if (ph_q == 2'h1) scl_lo_q <= 1'b0;
          else if (ph_q == 2'h2) begin
            sda_drv_q <= 1'b1;
            st_q <= M_IDLE;
            busy_q <= 1'b0;
            done_ev <= 1'b1;
            nack_ev <= nack_q;
          end
        end
        default: st_q <= M_IDLE;
      endcase
    end
  end

  // apb slave, answers in the access cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ptr_q <= 8'h00;
      wdat_q <= 8'h00;
      rd_q <= 1'b0;
      div_q <= DIV_DEFAULT;
      irq_mask_q <= 2'h0;
      irq_stat_q <= 2'h0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      irq <= |(irq_stat_q & irq_mask_q);
      if (apb_acc && pready && pwrite && paddr == APB_IRQ_STAT)
        irq_stat_q <= (irq_stat_q & ~pwdata[1:0]) | {nack_ev, done_ev};
      else irq_stat_q <= irq_stat_q | {nack_ev, done_ev};
      // writes land only at the edge where pready is seen high
      if (apb_acc && pready && pwrite && !busy_q) begin
        case (paddr)
          APB_CTRL: rd_q <= pwdata[1];
          APB_PTR: ptr_q <= pwdata[7:0];
          APB_WDATA: wdat_q <= pwdata[7:0];
          APB_IRQ_MASK: irq_mask_q <= pwdata[1:0];
          APB_DIV: if (pwdata[15:0] != 16'h0000) div_q <= pwdata[15:0];
          default: ;
        endcase
      end
      if (psel && !penable && !pwrite) begin
        case (paddr)
          APB_CTRL: prdata <= {30'h0, rd_q, 1'b0};
          APB_PTR: prdata <= {24'h0, ptr_q};
          APB_WDATA: prdata <= {24'h0, wdat_q};
          APB_RDATA: prdata <= {24'h0, rdat_q};
          APB_STATUS: prdata <= {30'h0, nack_q, busy_q};
          APB_IRQ_STAT: prdata <= {30'h0, irq_stat_q};
          APB_IRQ_MASK: prdata <= {30'h0, irq_mask_q};
          APB_DIV: prdata <= {16'h0, div_q};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign link.scl_o = 1'b0;
  assign link.scl_oe = scl_lo_q;
  assign link.sda_m_o = 1'b0;
  assign link.sda_m_oe = !sda_drv_q;
endmodule

/* tb/i2c_link_monitor.sv */
`timescale 1ns/1ps
module i2c_link_monitor
  import charger_i2c_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe
);
  logic scl_q, sda_q, rd_q;
  logic [4:0] cnt_q;
  logic [7:0] shift_q;
  wire m_low = sda_m_oe && !sda_m_o;
  wire s_low = sda_s_oe && !sda_s_o;
  wire scl_rise = scl && !scl_q;
  wire start_det = scl && scl_q && sda_q && !sda;
  wire stop_det = scl && scl_q && !sda_q && sda;
  // idle high in reset so the first sample after release sees no edge
  always_ff @(posedge core_clk) begin
    scl_q <= rst ? 1'b1 : scl;
    sda_q <= rst ? 1'b1 : sda;
  end
  always_ff @(posedge core_clk) begin
    // a stop closes the frame, so the next start counts from zero again
    if (rst || start_det || stop_det) begin
      cnt_q <= 5'd0;
      rd_q <= 1'b0;
    end else if (scl_rise) begin
      cnt_q <= cnt_q + 5'd1;
      rd_q <= (cnt_q == 5'd7) ? sda : rd_q;
    end
  end
  always_ff @(posedge core_clk) begin
    if (scl_rise) begin
      shift_q <= {shift_q[6:0], sda};
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_start; start_det; endsequence
  sequence s_stop; stop_det; endsequence
  sequence s_ack_slot; scl_rise && cnt_q == 5'd8; endsequence
  property p_start_by_master; s_start |-> m_low; endproperty
  a_start_by_master: assert property (p_start_by_master)
    else $error("start not made by master");
  property p_stop_by_master; s_stop |-> $past(m_low); endproperty
  a_stop_by_master: assert property (p_stop_by_master)
    else $error("stop not made by master");
  // a stop or repeated start costs one more clock rise after the last byte
  property p_stop_whole_bytes; s_stop |-> cnt_q == 5'd19 || cnt_q == 5'd28; endproperty
  a_stop_whole_bytes: assert property (p_stop_whole_bytes)
    else $error("stop after partial byte");
  property p_restart_pos;
    (s_start and cnt_q != 5'd0) |-> cnt_q == 5'd19 && !rd_q;
  endproperty
  a_restart_pos: assert property (p_restart_pos)
    else $error("repeated start misplaced");
  property p_addr_ack;
    (s_ack_slot and shift_q[7:1] == DEV_ADDR) |-> s_low && !sda;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("address not acknowledged");
  property p_ack_held; (s_ack_slot and s_low) |=> s_low [*3]; endproperty
  a_ack_held: assert property (p_ack_held)
    else $error("acknowledge dropped early");
  property p_ptr_ack; scl_rise && cnt_q == 5'd17 && !rd_q |-> s_low; endproperty
  a_ptr_ack: assert property (p_ptr_ack)
    else $error("pointer byte not acknowledged");
  property p_read_owner; scl_rise && rd_q && cnt_q inside {[9:16]} |-> !m_low; endproperty
  a_read_owner: assert property (p_read_owner)
    else $error("master drives data in read");
  property p_last_nack; scl_rise && rd_q && cnt_q == 5'd17 |-> sda && !s_low; endproperty
  a_last_nack: assert property (p_last_nack)
    else $error("final byte not refused");
  property p_stable_high; scl && scl_q |-> $stable(s_low); endproperty
  a_stable_high: assert property (p_stable_high)
    else $error("slave moved data with clock high");
  c_read_stop: cover property (s_stop ##0 rd_q);
endmodule

/* tb/charger_i2c_register_slave_tb_top.sv */
`timescale 1ns/1ps
module charger_i2c_register_slave_tb_top
  import charger_i2c_pkg::*;
;
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] data;
    logic [7:0] rb;
    logic [7:0] exp;
  } row_t;
  // each row writes ptr, then reads rb back; writes to 0xFF only open a read
  row_t rows [9] = '{
    '{8'h04, 8'hFF, 8'h04, 8'hDF}, '{8'h05, 8'hFF, 8'h05, 8'h1F},
    '{8'h06, 8'h0A, 8'h06, 8'h0A}, '{8'h07, 8'hC3, 8'h07, 8'hC3},
    '{8'hFF, 8'h55, 8'h07, 8'hC3}, '{8'h00, 8'h77, 8'h00, PART_ID_DEFAULT},
    '{8'h01, 8'h00, 8'h01, 8'hE3}, '{8'h02, 8'h00, 8'h02, 8'h21},
    '{8'h03, 8'h20, 8'h03, 8'h20}};
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] charger_phase;
  logic undervoltage_lockout, input_undervoltage_flag, input_overvoltage_flag;
  logic input_below_battery_flag, status_interrupt_output_n, soft_reset_pulse_q;
  logic [7:0] general_state_flags, function_control_q, charge_current_q;
  logic [7:0] charge_voltage_q, health_sink_q, got;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  int pulses = 0;
  i2c_link_if i2c_link_if_i ();
  charger_i2c_slave charger_i2c_slave_i (.core_clk(core_clk), .rst(rst),
    .link(i2c_link_if_i.slave), .charger_phase(charger_phase),
    .undervoltage_lockout(undervoltage_lockout),
    .input_undervoltage_flag(input_undervoltage_flag),
    .input_overvoltage_flag(input_overvoltage_flag),
    .input_below_battery_flag(input_below_battery_flag),
    .general_state_flags(general_state_flags),
    .status_interrupt_output_n(status_interrupt_output_n),
    .function_control_q(function_control_q), .charge_current_q(charge_current_q),
    .charge_voltage_q(charge_voltage_q), .health_sink_q(health_sink_q),
    .soft_reset_pulse_q(soft_reset_pulse_q));
  charger_i2c_master charger_i2c_master_i (.core_clk(core_clk), .rst(rst),
    .link(i2c_link_if_i.master), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  i2c_link_monitor i2c_link_monitor_i (.core_clk(core_clk), .rst(rst),
    .scl(i2c_link_if_i.scl), .sda(i2c_link_if_i.sda), .sda_m_o(i2c_link_if_i.sda_m_o),
    .sda_m_oe(i2c_link_if_i.sda_m_oe), .sda_s_o(i2c_link_if_i.sda_s_o),
    .sda_s_oe(i2c_link_if_i.sda_s_oe));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic tally_and_finish();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    pulses <= pulses + ((soft_reset_pulse_q === 1'b1) ? 1 : 0);
    if (cycles == 90000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                     output logic [31:0] rdata);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic w(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] unused;
    apb(1'b1, addr, data, unused);
  endtask
  task automatic chk_irq(input logic exp);
    repeat (2) @(posedge core_clk);
    check(irq, exp);
  endtask
  task automatic xfer(input logic [7:0] ptr, input logic [7:0] data, input logic rd_op,
                      output logic [7:0] res);
    logic [31:0] v;
    w(APB_PTR, {24'h0, ptr});
    w(APB_WDATA, {24'h0, data});
    w(APB_CTRL, rd_op ? 32'h3 : 32'h1);
    while (irq !== 1'b1) @(posedge core_clk);
    apb(1'b0, APB_STATUS, 32'h0, v);
    check(v & 32'h3, 32'h0);
    apb(1'b0, APB_RDATA, 32'h0, v);
    res = v[7:0];
    w(APB_IRQ_STAT, 32'h3);
  endtask
  initial begin
    logic [31:0] v;
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {charger_phase, undervoltage_lockout, input_undervoltage_flag} = {PHASE_CC, 2'b00};
    {input_overvoltage_flag, input_below_battery_flag} = 2'b11;
    general_state_flags = 8'h21;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    check({irq, pready, status_interrupt_output_n, function_control_q}, 32'h100);
    w(APB_IRQ_MASK, 32'h1);
    apb(1'b0, 8'h20, 32'h0, v);
    check(v, 32'h0);
    foreach (rows[i]) begin
      xfer(rows[i].ptr, rows[i].data, 1'b0, got);
      xfer(rows[i].rb, 8'h00, 1'b1, got);
      check(got, rows[i].exp);
    end
    check({function_control_q, charge_current_q, charge_voltage_q, health_sink_q},
          32'hDF1F0AC3);
    check(status_interrupt_output_n, 1'b0);
    xfer(REG_INT_MASK, 8'h02, 1'b0, got);
    check(status_interrupt_output_n, 1'b1);
    for (int p = 0; p < 8; p++) begin
      charger_phase <= p[2:0];
      xfer(REG_CHARGER_FLAGS, 8'h00, 1'b1, got);
      check(got[6:4], (p inside {0, 2, 4, 6, 7}) ? p[2:0] : 3'h0);
    end
    charger_phase <= PHASE_CC;
    undervoltage_lockout <= 1'b1;
    xfer(REG_CHARGER_FLAGS, 8'h00, 1'b1, got);
    check(got[7], 1'b0);
    undervoltage_lockout <= 1'b0;
    xfer(REG_FUNC_CTRL, 8'h00, 1'b0, got);
    xfer(REG_CHARGER_FLAGS, 8'h00, 1'b1, got);
    check({got[7], got[3:0]}, 5'b00111);
    // leave a transfer's done flag pending to exercise the mask
    w(APB_CTRL, 32'h3);
    while (irq !== 1'b1) @(posedge core_clk);
    w(APB_IRQ_MASK, 32'h0);
    chk_irq(1'b0);
    w(APB_IRQ_MASK, 32'h1);
    chk_irq(1'b1);
    w(APB_IRQ_STAT, 32'h3);
    chk_irq(1'b0);
    xfer(REG_SOFT_RESET, 8'h00, 1'b0, got);
    check(pulses, 1);
    check(pslverr, 1'b0);
    tally_and_finish();
  end
endmodule
